//--- hdl/stream_cfg_pkg.sv
// Constants and carriers for the converter stream configuration registers
package stream_cfg_pkg;
	// Geometry
	localparam int NUM_CHAN = 4;
	localparam int ADDR_W   = 8;
	localparam int IDX_W    = 6;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CHAN_SEL = 6'h05;
	localparam logic [IDX_W-1:0] IDX_PAT2_LO  = 6'h1B;
	localparam logic [IDX_W-1:0] IDX_PAT2_HI  = 6'h1C;
	localparam logic [IDX_W-1:0] IDX_FMT      = 6'h21;
	localparam logic [IDX_W-1:0] IDX_CHAN     = 6'h22;

	// Byte addresses on the bus
	localparam logic [ADDR_W-1:0] ADR_CHAN_SEL = {IDX_CHAN_SEL, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_PAT2_LO  = {IDX_PAT2_LO, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_PAT2_HI  = {IDX_PAT2_HI, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_FMT      = {IDX_FMT, 2'b00};
	localparam logic [ADDR_W-1:0] ADR_CHAN     = {IDX_CHAN, 2'b00};

	// Field positions
	localparam int FLD_LSB_FIRST = 7;
	localparam int FLD_LOW_RATE  = 3;
	localparam int FLD_RES_HI    = 2;
	localparam int FLD_RES_LO    = 0;
	localparam int FLD_OUT_RST   = 1;
	localparam int FLD_PWR_DN    = 0;

	// Values after reset
	localparam logic [7:0] RST_PAT2_LO  = 8'h00;
	localparam logic [7:0] RST_PAT2_HI  = 8'h00;
	localparam logic [7:0] RST_FMT      = 8'h00;
	localparam logic [7:0] RST_CHAN     = 8'h00;
	localparam logic [3:0] RST_CHAN_SEL = 4'hF;

	// Resolution codes
	localparam logic [2:0] RES_NATIVE = 3'h0;
	localparam logic [2:0] RES_8      = 3'h1;
	localparam logic [2:0] RES_10     = 3'h2;
	localparam logic [2:0] RES_12     = 3'h3;
	localparam logic [2:0] RES_14     = 3'h4;

	// Serial word sizes in bits
	localparam logic [3:0] BITS_8  = 4'h8;
	localparam logic [3:0] BITS_10 = 4'hA;
	localparam logic [3:0] BITS_12 = 4'hC;
	localparam logic [3:0] BITS_14 = 4'hE;

	// Global stream format
	typedef struct packed {
		logic       lsb_first;
		logic       low_rate;
		logic [2:0] resolution;
	} stream_fmt_s;

	// One register access handed from the bus slave
	typedef struct packed {
		logic             wr;
		logic [IDX_W-1:0] idx;
		logic [7:0]       wdata;
	} reg_acc_s;
endpackage

//--- hdl/apb_byte_slave.sv
// APB slave front end carrying byte-wide register accesses
`timescale 1ns/10ps
module apb_byte_slave
	import stream_cfg_pkg::*;
(
	// Clock, enable, reset
	input  wire logic              clk,
	input  wire logic              ce,
	input  wire logic              srst,
	// APB
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	// Register side
	input  wire logic              hit,
	input  wire logic [7:0]        rdata,
	output reg_acc_s               acc
);
	logic [7:0] rd_r;   // Captured read byte
	logic [7:0] rd_nxt; // Next read byte
	logic       ok;     // Aligned and mapped

	// Misaligned addresses count as unmapped
	assign ok = hit && (paddr[1:0] == 2'b00);

	// Stall while frozen so no transfer is lost
	assign pready  = ce;
	assign pslverr = psel && penable && ce && !ok;
	assign prdata  = {24'h000000, rd_r};

	// Write lands only at the completing edge
	assign acc.wr    = psel && penable && pwrite && ce && ok;
	assign acc.idx   = paddr[ADDR_W-1:2];
	assign acc.wdata = pwdata[7:0];

	// Read byte sampled in the setup cycle
	always_comb begin
		rd_nxt = rd_r;
		if (ce && psel && !penable && !pwrite) begin
			rd_nxt = ok ? rdata : 8'h00;
		end
	end

	// Read byte register; holds through the access phase
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_r <= 8'h00;
		end else begin
			rd_r <= rd_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Unmapped access is flagged and never written
	unmapped_err_a: assert property (psel && penable && ce && !ok |-> pslverr && !acc.wr)
		else $error("unmapped access not flagged");
endmodule

//--- hdl/chan_ctrl_bank.sv
// Per-channel output reset and power-down bits
`timescale 1ns/10ps
module chan_ctrl_bank
	import stream_cfg_pkg::*;
#(
	parameter int N = NUM_CHAN
)(
	// Clock, enable, reset
	input  wire logic         clk,
	input  wire logic         ce,
	input  wire logic         srst,
	// Write side
	input  wire logic         wr,
	input  wire logic [N-1:0] sel,
	input  wire logic [7:0]   wdata,
	// Channel controls
	output logic [N-1:0]      out_rst,
	output logic [N-1:0]      pwr_dn
);
	// One slice per channel; only selected channels take a write
	for (genvar c = 0; c < N; c++) begin : g_chan
		logic rst_r;   // Output held in reset
		logic rst_nxt;
		logic pd_r;    // Channel powered down
		logic pd_nxt;

		// Next state of this channel's bits
		always_comb begin
			rst_nxt = rst_r;
			pd_nxt  = pd_r;
			if (ce && wr && sel[c]) begin
				rst_nxt = wdata[FLD_OUT_RST];
				pd_nxt  = wdata[FLD_PWR_DN];
			end
		end

		// Channel registers; reset acts even while frozen
		always_ff @(posedge clk) begin
			if (srst) begin
				rst_r <= RST_CHAN[FLD_OUT_RST];
				pd_r  <= RST_CHAN[FLD_PWR_DN];
			end else begin
				rst_r <= rst_nxt;
				pd_r  <= pd_nxt;
			end
		end

		assign out_rst[c] = rst_r;
		assign pwr_dn[c]  = pd_r;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	out_reset_a: assert property (
		ce && wr && sel[0] |=> out_rst[0] == $past(wdata[FLD_OUT_RST]))
		else $error("output reset bit not taken");
	power_down_a: assert property (
		ce && wr && sel[N-1] |=> pwr_dn[N-1] == $past(wdata[FLD_PWR_DN]))
		else $error("power-down bit not taken");
	unselected_hold_a: assert property (
		!(ce && wr && sel[1]) |=> $stable(pwr_dn[1]) && $stable(out_rst[1]))
		else $error("unselected channel changed");
	pd_seen_c: cover property (ce && wr && sel[2] && wdata[FLD_PWR_DN] ##1 pwr_dn[2]);
endmodule

//--- hdl/adc_stream_config_regs.sv
// Stream configuration register bank on APB with per-channel controls
`timescale 1ns/10ps
module adc_stream_config_regs
	import stream_cfg_pkg::*;
#(
	parameter int N = NUM_CHAN
)(
	// Clock, enable, reset
	input  wire logic              clk,
	input  wire logic              ce,
	input  wire logic              srst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	// Test pattern two
	output logic [15:0]            pattern_two,
	// Global stream format
	output stream_fmt_s            stream_fmt,
	output logic [3:0]             word_bits,
	// Per-channel controls
	output logic [N-1:0]           chan_out_reset,
	output logic [N-1:0]           chan_power_down
);
	reg_acc_s    acc;          // Access from the bus slave
	logic        hit;          // Index maps to a register
	logic [7:0]  rdata;        // Read mux result

	logic [7:0]  pat_lo_r;     // Pattern two low byte
	logic [7:0]  pat_lo_nxt;
	logic [7:0]  pat_hi_r;     // Pattern two high byte
	logic [7:0]  pat_hi_nxt;
	stream_fmt_s fmt_r;        // Stream format fields
	stream_fmt_s fmt_nxt;
	logic [3:0]  bits_r;       // Decoded word size
	logic [3:0]  bits_nxt;
	logic [N-1:0] sel_r;       // Channels that per-channel writes reach
	logic [N-1:0] sel_nxt;
	logic [7:0]  chan_view;    // Per-channel read value

	// Write strobes per register
	logic        wr_lo;
	logic        wr_hi;
	logic        wr_fmt;
	logic        wr_chan;
	logic        wr_sel;

	// Bus front end
	apb_byte_slave u_apb (
		.clk     (clk),
		.ce      (ce),
		.srst    (srst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.pslverr (pslverr),
		.prdata  (prdata),
		.hit     (hit),
		.rdata   (rdata),
		.acc     (acc)
	);

	// Address decode
	always_comb begin
		case (acc.idx)
			IDX_PAT2_LO,
			IDX_PAT2_HI,
			IDX_FMT,
			IDX_CHAN,
			IDX_CHAN_SEL: hit = 1'b1;
			default:      hit = 1'b0;
		endcase
	end

	// Strobes already carry enable and completion
	// A frozen or stalled transfer therefore never reaches a register
	assign wr_lo   = acc.wr && (acc.idx == IDX_PAT2_LO);
	assign wr_hi   = acc.wr && (acc.idx == IDX_PAT2_HI);
	assign wr_fmt  = acc.wr && (acc.idx == IDX_FMT);
	assign wr_chan = acc.wr && (acc.idx == IDX_CHAN);
	assign wr_sel  = acc.wr && (acc.idx == IDX_CHAN_SEL);

	// Pattern two bytes
	always_comb begin
		pat_lo_nxt = pat_lo_r;
		pat_hi_nxt = pat_hi_r;
		if (wr_lo) begin
			pat_lo_nxt = acc.wdata;
		end
		if (wr_hi) begin
			pat_hi_nxt = acc.wdata;
		end
	end

	// Pattern byte registers; reset wins over a write
	always_ff @(posedge clk) begin
		if (srst) begin
			pat_lo_r <= RST_PAT2_LO;
			pat_hi_r <= RST_PAT2_HI;
		end else begin
			pat_lo_r <= pat_lo_nxt;
			pat_hi_r <= pat_hi_nxt;
		end
	end

	// Stream format fields; unused bits are dropped and read zero
	always_comb begin
		fmt_nxt = fmt_r;
		if (wr_fmt) begin
			fmt_nxt.lsb_first  = acc.wdata[FLD_LSB_FIRST];
			fmt_nxt.low_rate   = acc.wdata[FLD_LOW_RATE];
			fmt_nxt.resolution = acc.wdata[FLD_RES_HI:FLD_RES_LO];
		end
	end

	// Word size decode; a code above 14 bits keeps the native width,
	// so a bad write cannot leave the serializer without a size
	always_comb begin
		case (fmt_r.resolution)
			RES_NATIVE: bits_nxt = BITS_8;
			RES_8:      bits_nxt = BITS_8;
			RES_10:     bits_nxt = BITS_10;
			RES_12:     bits_nxt = BITS_12;
			RES_14:     bits_nxt = BITS_14;
			default:    bits_nxt = BITS_8;
		endcase
		if (!ce) begin
			bits_nxt = bits_r;
		end
	end

	// Format and size registers; each field takes its own bit of the reset byte
	always_ff @(posedge clk) begin
		if (srst) begin
			fmt_r.lsb_first  <= RST_FMT[FLD_LSB_FIRST];
			fmt_r.low_rate   <= RST_FMT[FLD_LOW_RATE];
			fmt_r.resolution <= RST_FMT[FLD_RES_HI:FLD_RES_LO];
			bits_r           <= BITS_8;
		end else begin
			fmt_r  <= fmt_nxt;
			bits_r <= bits_nxt;
		end
	end

	// Channel select; all channels are reached after reset
	always_comb begin
		sel_nxt = sel_r;
		if (wr_sel) begin
			sel_nxt = acc.wdata[N-1:0];
		end
	end

	// Channel select register
	always_ff @(posedge clk) begin
		if (srst) begin
			sel_r <= RST_CHAN_SEL[N-1:0];
		end else begin
			sel_r <= sel_nxt;
		end
	end

	// Per-channel bits live in their own slices
	chan_ctrl_bank #(.N(N)) u_chan (
		.clk     (clk),
		.ce      (ce),
		.srst    (srst),
		.wr      (wr_chan),
		.sel     (sel_r),
		.wdata   (acc.wdata),
		.out_rst (chan_out_reset),
		.pwr_dn  (chan_power_down)
	);

	// Per-channel read shows the lowest selected channel's live state;
	// with nothing selected it reads zero
	always_comb begin
		chan_view = 8'h00;
		for (int c = N - 1; c >= 0; c--) begin
			if (sel_r[c]) begin
				chan_view = 8'h00;
				chan_view[FLD_OUT_RST] = chan_out_reset[c];
				chan_view[FLD_PWR_DN]  = chan_power_down[c];
			end
		end
	end

	// Read mux; reserved bits read as zero
	always_comb begin
		rdata = 8'h00;
		case (acc.idx)
			IDX_PAT2_LO: rdata = pat_lo_r;
			IDX_PAT2_HI: rdata = pat_hi_r;
			IDX_FMT: begin
				rdata[FLD_LSB_FIRST]         = fmt_r.lsb_first;
				rdata[FLD_LOW_RATE]          = fmt_r.low_rate;
				rdata[FLD_RES_HI:FLD_RES_LO] = fmt_r.resolution;
			end
			IDX_CHAN:     rdata = chan_view;
			IDX_CHAN_SEL: rdata[N-1:0] = sel_r;
			default:      rdata = 8'h00;
		endcase
	end

	// Outputs straight from flip-flops
	assign pattern_two = {pat_hi_r, pat_lo_r};
	assign stream_fmt  = fmt_r;
	assign word_bits   = bits_r;

	// Checks; all of them stand down while reset is applied
	// Write checks look one edge later, once the bytes have landed; the 14-bit size check looks two edges later
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	pattern_low_a: assert property (
		wr_lo |=> pattern_two[7:0] == $past(acc.wdata) && $stable(pattern_two[15:8]))
		else $error("pattern low byte not written");

	pattern_high_a: assert property (
		wr_hi |=> pattern_two[15:8] == $past(acc.wdata) && $stable(pattern_two[7:0]))
		else $error("pattern high byte not written");

	pattern_reset_a: assert property (
		$past(srst) |-> pattern_two == 16'h0000)
		else $error("pattern not cleared by reset");

	res_fourteen_a: assert property (
		wr_fmt && acc.wdata[FLD_RES_HI:FLD_RES_LO] == RES_14 && ce ##1 ce
		|=> word_bits == BITS_14)
		else $error("14-bit word size not selected");

	res_ten_a: assert property (
		fmt_r.resolution == RES_10 && ce |=> word_bits == BITS_10)
		else $error("10-bit word size not selected");

	bit_order_a: assert property (
		wr_fmt |=> stream_fmt.lsb_first == $past(acc.wdata[FLD_LSB_FIRST])
			&& stream_fmt.low_rate == $past(acc.wdata[FLD_LOW_RATE]))
		else $error("bit order or low rate flag wrong");

	frozen_hold_a: assert property (
		!ce |=> $stable(stream_fmt) && $stable(pattern_two))
		else $error("state moved while frozen");

	chan_write_a: assert property (
		wr_chan && sel_r[0] |=> chan_power_down[0] == $past(acc.wdata[FLD_PWR_DN])
			&& chan_out_reset[0] == $past(acc.wdata[FLD_OUT_RST]))
		else $error("channel bits not written");

	// Reset values on the first edge after release
	fmt_reset_a: assert property (
		$past(srst) |-> stream_fmt.lsb_first == RST_FMT[FLD_LSB_FIRST]
			&& stream_fmt.resolution == RST_FMT[FLD_RES_HI:FLD_RES_LO] && word_bits == BITS_8)
		else $error("stream format not cleared by reset");

	chan_clear_a: assert property (
		$past(srst) |-> chan_out_reset == '0 && chan_power_down == '0)
		else $error("channel bits not cleared by reset");

	// Registers hold unless their own strobe fires
	pattern_hold_a: assert property (
		!wr_lo && !wr_hi |=> $stable(pattern_two))
		else $error("pattern moved without a write");

	fmt_hold_a: assert property (
		!wr_fmt |=> $stable(stream_fmt))
		else $error("stream format moved without a write");

	chan_hold_a: assert property (
		!wr_chan |=> $stable(chan_out_reset) && $stable(chan_power_down))
		else $error("channel bits moved without a write");

	// Every documented word size decodes
	res_native_a: assert property (
		fmt_r.resolution == RES_NATIVE && ce |=> word_bits == BITS_8)
		else $error("native word size not selected");

	res_eight_a: assert property (
		fmt_r.resolution == RES_8 && ce |=> word_bits == BITS_8)
		else $error("8-bit word size not selected");

	res_twelve_a: assert property (
		fmt_r.resolution == RES_12 && ce |=> word_bits == BITS_12)
		else $error("12-bit word size not selected");

	// Channel select and per-channel read view
	sel_write_a: assert property (
		wr_sel |=> sel_r == $past(acc.wdata[N-1:0]))
		else $error("channel select not written");

	chan_read_a: assert property (
		sel_r[0] |-> chan_view[FLD_OUT_RST] == chan_out_reset[0]
			&& chan_view[FLD_PWR_DN] == chan_power_down[0])
		else $error("channel read view wrong");

	// Main scenarios
	pattern_write_c: cover property (wr_lo ##[1:20] wr_hi);
	lsb_first_c:     cover property (wr_fmt && acc.wdata[FLD_LSB_FIRST]);
	res_fourteen_c:  cover property (word_bits == BITS_14);
	chan_reset_c:    cover property (wr_chan && sel_r == 4'h2 && acc.wdata[FLD_OUT_RST]);
endmodule

//--- testbench/tb.sv
// Self-checking bench for the stream configuration register bank
`timescale 1ns/10ps
module tb
	import stream_cfg_pkg::*;
;
	// Clock, enable, reset
	logic        clk     = 1'b0;
	logic        ce      = 1'b1;
	logic        srst    = 1'b1;
	// APB master side
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	// Block outputs
	logic [15:0] pattern_two;
	stream_fmt_s stream_fmt;
	logic [3:0]  word_bits;
	logic [3:0]  chan_out_reset;
	logic [3:0]  chan_power_down;
	// Reference model state
	logic [7:0]  m_lo, m_hi, m_fmt;
	logic [3:0]  m_sel, m_rst, m_pd;
	logic [31:0] seed    = 32'h5351010F;
	logic [31:0] rd, r;
	logic        er;
	int          errors  = 0;
	int          n_tests = 0;
	logic [31:0] exp_q [$];        // Expected read data, in request order
	logic [7:0]  adr_tab [8] = '{8'h14, 8'h6C, 8'h70, 8'h84, 8'h88, 8'h00, 8'h6D, 8'hFC};

	adc_stream_config_regs uut (
		.clk(clk), .ce(ce), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.pattern_two(pattern_two), .stream_fmt(stream_fmt), .word_bits(word_bits),
		.chan_out_reset(chan_out_reset), .chan_power_down(chan_power_down)
	);

	// 100 MHz clock
	always #5 clk = ~clk;

	// Xorshift source, fixed seed
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// One comparison, counted
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Model reset state
	task automatic model_reset();
		{m_lo, m_hi, m_fmt, m_rst, m_pd} = '0;
		m_sel = 4'hF;
	endtask

	// Word size from resolution code; spare codes fall back to 8
	function automatic logic [3:0] exp_bits(input logic [2:0] c);
		case (c)
			3'h2: return 4'hA;
			3'h3: return 4'hC;
			3'h4: return 4'hE;
			default: return 4'h8;
		endcase
	endfunction

	// Expected read byte; channel read shows the lowest selected channel
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h14: return {28'h0, m_sel};
			8'h6C: return {24'h0, m_lo};
			8'h70: return {24'h0, m_hi};
			8'h84: return {24'h0, m_fmt & 8'h8F};
			8'h88: begin
				for (int i = 0; i < 4; i++)
					if (m_sel[i])
						return {30'h0, m_rst[i], m_pd[i]};
				return 32'h0;
			end
			default: return 32'h0;
		endcase
	endfunction

	// Mapped means one of the five aligned byte addresses
	function automatic logic mapped(input logic [7:0] a);
		return a inside {8'h14, 8'h6C, 8'h70, 8'h84, 8'h88};
	endfunction

	// Model write, applied at the completing edge
	task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h14: m_sel = d[3:0];
			8'h6C: m_lo = d;
			8'h70: m_hi = d;
			8'h84: m_fmt = d;
			8'h88: begin
				for (int i = 0; i < 4; i++)
					if (m_sel[i]) begin
						m_rst[i] = d[1];
						m_pd[i]  = d[0];
					end
			end
			default: ;
		endcase
	endtask

	// One APB transfer; ce held low for stall cycles of the access phase
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input int stall, input logic keep);
		int n;
		n = 0;
		if (!wr)
			exp_q.push_back(exp_rd(a));
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		if (stall > 0)
			ce <= 1'b0;
		// Wait for pready; only the watchdog ends a hang
		forever begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
			n++;
			if (n == stall)
				ce <= 1'b1;
		end
		chk(n, stall);
		chk(pslverr, !mapped(a));
		if (!wr)
			chk(prdata, exp_q.pop_front());
		else if (mapped(a))
			model_wr(a, d[7:0]);
		penable <= 1'b0;
		// An idle edge keeps psel from being driven twice in one step
		if (!keep) begin
			psel <= 1'b0;
			@(posedge clk);
		end
	endtask

	// Outputs against model, after word size has settled
	task automatic chk_outs();
		repeat (2) @(posedge clk);
		chk(pattern_two, {m_hi, m_lo});
		chk(stream_fmt, {m_fmt[7], m_fmt[3], m_fmt[2:0]});
		chk(word_bits, exp_bits(m_fmt[2:0]));
		chk(chan_out_reset, m_rst);
		chk(chan_power_down, m_pd);
	endtask

	// Reset pulse of four cycles, then reset values
	task automatic do_reset();
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		model_reset();
		chk_outs();
		for (int i = 0; i < 5; i++)
			apb(1'b0, adr_tab[i], 32'h0, 0, 1'b0);
	endtask

	// Verdict and end of run
	task automatic summarize();
		$display("checks=%0d errors=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial begin
		do_reset();
		// Every resolution code with random flag bits
		for (int c = 0; c < 8; c++) begin
			r = rnd();
			apb(1'b1, 8'h84, {r[31:8], r[7:3], c[2:0]}, 0, 1'b1);
			apb(1'b0, 8'h84, 32'h0, 1, 1'b0);
			chk_outs();
		end
		// Random traffic incl. unmapped, misaligned, stalls, back to back
		for (int k = 0; k < 120; k++) begin
			r = rnd();
			apb(r[0], adr_tab[r[3:1]], rnd(), int'(r[5:4]) % 3, r[6]);
			if (!r[6])
				chk_outs();
		end
		psel <= 1'b0;
		@(posedge clk);
		// Second reset mid-run
		do_reset();
		summarize();
	end

	// Watchdog
	initial begin
		#200000;
		errors++;
		summarize();
	end
endmodule
